// >>> design/nand_seq_regs.svh
// Register offsets, field positions, flash command bytes and timing counts for the NAND sequencer.
`ifndef NAND_SEQ_REGS_SVH
`define NAND_SEQ_REGS_SVH

`define REG_CMD_OFS      6'h00
`define REG_COL_OFS      6'h04
`define REG_ROW_OFS      6'h08
`define REG_ROW2_OFS     6'h0c
`define REG_DATA_OFS     6'h10
`define REG_STAT_OFS     6'h14
`define REG_CTRL_OFS     6'h18

`define CTRL_WP_N_BIT    0
`define CTRL_RST_VAL     1'h0
`define STAT_RUN_BIT     0
`define STAT_RB_BIT      1
`define STAT_ERR_BIT     2
`define STAT_CACHE_BIT   3
`define STAT_PROG_BIT    4
`define STAT_MOPEN_BIT   5
`define STAT_MSEC_BIT    6
`define STAT_FAIL_BIT    7

`define FL_READ_SETUP    8'h00
`define FL_READ_GO       8'h30
`define FL_CACHE_NEXT    8'h31
`define FL_CACHE_LAST    8'h3f
`define FL_MREAD_SETUP   8'h60
`define FL_PROG_LOAD     8'h80
`define FL_PROG_COL      8'h85
`define FL_PROG_GO       8'h10
`define FL_MPROG_FIRST   8'h11
`define FL_MPROG_SECOND  8'h81
`define FL_STATUS        8'h70
`define FL_RESET         8'hff

`define CLK_PERIOD_NS    10
`define T_STROBE_LOW_NS  15
`define T_STROBE_HIGH_NS 10
`define T_BUSY_RISE_NS   100
`define STROBE_LOW_CYC   ((`T_STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HIGH_CYC  ((`T_STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_RISE_CYC    ((`T_BUSY_RISE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> design/nand_seq_pkg.sv
// Types shared by the NAND sequencer and its byte-cycle engine.
package nand_seq_pkg;
  typedef enum logic [3:0] {
    OP_READ, OP_READ_QUICK, OP_CACHE_NEXT, OP_CACHE_LAST, OP_MULTI_READ,
    OP_PROG_LOAD, OP_COL_CHANGE, OP_PROG_CONFIRM, OP_MULTI_FIRST, OP_MULTI_SECOND,
    OP_STATUS, OP_RESET, OP_DATA_WR, OP_DATA_RD
  } op_t;
  typedef enum logic [1:0] {K_CMD, K_ADDR, K_DWR, K_DRD} kind_t;
endpackage

// >>> design/nand_byte_cycle.sv
// One strobed byte cycle on the flash pins: command, address, data write or data read.
`timescale 1ns/100ps
module nand_byte_cycle
  import nand_seq_pkg::*;
#(
  parameter int LOW_CYC  = 2,
  parameter int HIGH_CYC = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Request
  input  wire logic         start_i,
  input  nand_seq_pkg::kind_t kind_i,
  input  wire logic [7:0]   byte_i,
  output logic              done_o,
  output logic [7:0]        rdata_o,
  // Flash pins
  input  wire logic [7:0]   io_i,
  output logic [7:0]        io_o,
  output logic              io_oe_o,
  output logic              cle_o,
  output logic              ale_o,
  output logic              we_n_o,
  output logic              read_strobe_n_o
);
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_LOW, E_HIGH} est_t;
  est_t       st_q;
  logic [7:0] cnt_q;
  logic       rd_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q            <= E_IDLE;
      cnt_q           <= 8'h00;
      rd_q            <= 1'b0;
      done_o          <= 1'b0;
      rdata_o         <= 8'h00;
      io_o            <= 8'h00;
      io_oe_o         <= 1'b0;
      cle_o           <= 1'b0;
      ale_o           <= 1'b0;
      we_n_o          <= 1'b1;
      read_strobe_n_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (st_q)
        E_IDLE: begin
          if (start_i) begin
            cle_o   <= (kind_i == K_CMD);
            ale_o   <= (kind_i == K_ADDR);
            io_o    <= byte_i;
            io_oe_o <= (kind_i != K_DRD);
            rd_q    <= (kind_i == K_DRD);
            st_q    <= E_SETUP;
          end
        end
        E_SETUP: begin
          // Latch selects and data settle one cycle before the strobe falls.
          we_n_o          <= rd_q;
          read_strobe_n_o <= !rd_q;
          cnt_q           <= 8'h00;
          st_q            <= E_LOW;
        end
        E_LOW: begin
          if (cnt_q == 8'(LOW_CYC - 1)) begin
            // Read data is taken just before the strobe rises, when it is surely valid.
            if (rd_q) rdata_o <= io_i;
            we_n_o          <= 1'b1;
            read_strobe_n_o <= 1'b1;
            cnt_q           <= 8'h00;
            st_q            <= E_HIGH;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        E_HIGH: begin
          if (cnt_q == 8'(HIGH_CYC - 1)) begin
            cle_o   <= 1'b0;
            ale_o   <= 1'b0;
            io_oe_o <= 1'b0;
            done_o  <= 1'b1;
            st_q    <= E_IDLE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: st_q <= E_IDLE;
      endcase
    end
  end

  logic [7:0] we_len_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) we_len_q <= 8'h00;
    else if (!we_n_o) we_len_q <= we_len_q + 8'h01;
    else we_len_q <= 8'h00;
  end

  a_we_low_width: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(we_n_o) |-> we_len_q == 8'(LOW_CYC)) else $error("write strobe low time wrong");
  a_latch_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cle_o && ale_o)) else $error("command and address latch both high");
  a_drive_on_write: assert property (@(posedge clk_i) disable iff (rst_i)
    !we_n_o |-> io_oe_o && read_strobe_n_o) else $error("bus not driven during write strobe");
  a_read_released: assert property (@(posedge clk_i) disable iff (rst_i)
    !read_strobe_n_o |-> !io_oe_o && we_n_o) else $error("bus driven during read strobe");
endmodule

// >>> design/nand_seq_host.sv
// Wishbone-controlled host sequencer that drives a NAND flash through its pins.
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
`include "nand_seq_regs.svh"
module nand_seq_host (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Flash pins
  input  wire logic [7:0]  io_i,
  output logic [7:0]       io_o,
  output logic             io_oe_o,
  output logic             cle_o,
  output logic             ale_o,
  output logic             ce_n_o,
  output logic             we_n_o,
  output logic             read_strobe_n_o,
  output logic             wp_n_o,
  input  wire logic        ready_busy_n_i
);
  import nand_seq_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_CYCLE, ST_WB, ST_READY} st_t;

  st_t         st_q;
  op_t         op_q;
  op_t         op_w;
  logic [3:0]  step_q;
  logic [7:0]  wait_q;
  logic [12:0] col_q;
  logic [16:0] row_q;
  logic [16:0] row2_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic        wp_ctrl_q;
  logic        err_q;
  logic        fresh_q;
  logic        cache_ok_q;
  logic        prog_open_q;
  logic        mopen_q;
  logic        msec_q;
  logic        fail_q;
  logic        wb_req;
  logic        cmd_wr;
  logic        legal;
  logic        cmd_go;
  logic        eng_start;
  logic        eng_done;
  logic [7:0]  eng_rdata;
  kind_t       c_kind;
  logic [7:0]  c_byte;
  logic        c_last;
  logic        c_wait;

  assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cmd_wr    = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `REG_CMD_OFS);
  assign op_w      = op_t'(wb_dat_i[3:0]);
  assign cmd_go    = cmd_wr && legal;
  assign eng_start = (st_q == ST_ISSUE);

  // Address byte n of the five-byte address: column low, column high, then three row bytes.
  function automatic logic [7:0] addr_byte(input logic [2:0] n, input logic [12:0] col, input logic [16:0] row);
    case (n)
      3'h0:    addr_byte = col[7:0];
      3'h1:    addr_byte = {3'h0, col[12:8]};
      3'h2:    addr_byte = row[7:0];
      3'h3:    addr_byte = row[15:8];
      default: addr_byte = {7'h00, row[16]};
    endcase
  endfunction

  // Which operations may be started in the present state.
  always_comb begin
    legal = (st_q == ST_IDLE) && (wb_dat_i[3:0] <= 4'hd);
    if (!ready_busy_n_i && op_w != OP_STATUS && op_w != OP_RESET) legal = 1'b0;
    if (mopen_q && op_w != OP_STATUS && op_w != OP_RESET && op_w != OP_MULTI_SECOND) legal = 1'b0;
    if (msec_q && op_w != OP_DATA_WR && op_w != OP_COL_CHANGE && op_w != OP_PROG_CONFIRM &&
        op_w != OP_STATUS && op_w != OP_RESET) legal = 1'b0;
    case (op_w)
      OP_READ_QUICK:   if (!fresh_q) legal = 1'b0;
      OP_CACHE_NEXT,
      OP_CACHE_LAST:   if (!cache_ok_q) legal = 1'b0;
      OP_MULTI_READ:   if (row_q[5:0] != row2_q[5:0] || row_q[6] == row2_q[6]) legal = 1'b0;
      OP_PROG_CONFIRM,
      OP_MULTI_FIRST,
      OP_COL_CHANGE:   if (!prog_open_q) legal = 1'b0;
      OP_MULTI_SECOND: if (!mopen_q) legal = 1'b0;
      default:         legal = legal;
    endcase
  end

  // Pin cycle for the present step of the running operation.
  always_comb begin
    c_kind = K_CMD;
    c_byte = 8'h00;
    c_last = 1'b1;
    c_wait = 1'b0;
    case (op_q)
      OP_READ: begin
        c_kind = (step_q == 4'h0 || step_q == 4'h6) ? K_CMD : K_ADDR;
        c_byte = (step_q == 4'h0) ? `FL_READ_SETUP : (step_q == 4'h6) ? `FL_READ_GO
               : addr_byte(3'(step_q - 4'h1), col_q, row_q);
        c_last = (step_q == 4'h6);
        c_wait = 1'b1;
      end
      OP_READ_QUICK: begin
        c_kind = (step_q == 4'h5) ? K_CMD : K_ADDR;
        c_byte = (step_q == 4'h5) ? `FL_READ_GO : addr_byte(step_q[2:0], col_q, row_q);
        c_last = (step_q == 4'h5);
        c_wait = 1'b1;
      end
      OP_CACHE_NEXT: begin c_byte = `FL_CACHE_NEXT; c_wait = 1'b1; end
      OP_CACHE_LAST: begin c_byte = `FL_CACHE_LAST; c_wait = 1'b1; end
      OP_MULTI_READ: begin
        c_kind = (step_q == 4'h0 || step_q == 4'h4 || step_q == 4'h8) ? K_CMD : K_ADDR;
        c_byte = (step_q == 4'h8) ? `FL_READ_GO
               : (step_q == 4'h0 || step_q == 4'h4) ? `FL_MREAD_SETUP
               : addr_byte(3'(step_q[1:0] + 2'h1), col_q, (step_q < 4'h4) ? row_q : row2_q);
        c_last = (step_q == 4'h8);
        c_wait = 1'b1;
      end
      OP_PROG_LOAD, OP_MULTI_SECOND: begin
        c_kind = (step_q == 4'h0) ? K_CMD : K_ADDR;
        c_byte = (step_q != 4'h0) ? addr_byte(3'(step_q - 4'h1), col_q, row_q)
               : (op_q == OP_PROG_LOAD) ? `FL_PROG_LOAD : `FL_MPROG_SECOND;
        c_last = (step_q == 4'h5);
      end
      OP_COL_CHANGE: begin
        c_kind = (step_q == 4'h0) ? K_CMD : K_ADDR;
        c_byte = (step_q == 4'h0) ? `FL_PROG_COL : addr_byte(3'(step_q - 4'h1), col_q, row_q);
        c_last = (step_q == 4'h2);
      end
      OP_PROG_CONFIRM: begin c_byte = `FL_PROG_GO; c_wait = 1'b1; end
      OP_MULTI_FIRST:  begin c_byte = `FL_MPROG_FIRST; c_wait = 1'b1; end
      OP_STATUS: begin
        c_kind = (step_q == 4'h0) ? K_CMD : K_DRD;
        c_byte = `FL_STATUS;
        c_last = (step_q == 4'h1);
      end
      OP_RESET:   begin c_byte = `FL_RESET; c_wait = 1'b1; end
      OP_DATA_WR: begin c_kind = K_DWR; c_byte = wdata_q; end
      OP_DATA_RD: c_kind = K_DRD;
      default:    c_last = 1'b1;
    endcase
  end

  // Sequencing of one operation, with the wait for the device's busy phase.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q   <= ST_IDLE;
      op_q   <= OP_READ;
      step_q <= 4'h0;
      wait_q <= 8'h00;
    end else begin
      case (st_q)
        ST_IDLE: if (cmd_go) begin
          op_q   <= op_w;
          step_q <= 4'h0;
          st_q   <= ST_ISSUE;
        end
        ST_ISSUE: st_q <= ST_CYCLE;
        ST_CYCLE: if (eng_done) begin
          step_q <= step_q + 4'h1;
          wait_q <= 8'h00;
          st_q   <= !c_last ? ST_ISSUE : c_wait ? ST_WB : ST_IDLE;
        end
        // Busy shows only some time after the strobe, so the pin is not trusted at once.
        ST_WB: if (wait_q == 8'(`BUSY_RISE_CYC - 1)) st_q <= ST_READY; else wait_q <= wait_q + 8'h01;
        ST_READY: if (ready_busy_n_i) st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Protocol bookkeeping that gates later operations.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fresh_q     <= 1'b1;
      cache_ok_q  <= 1'b0;
      prog_open_q <= 1'b0;
      mopen_q     <= 1'b0;
      msec_q      <= 1'b0;
    end else if (cmd_go && op_w != OP_STATUS && op_w != OP_DATA_RD && op_w != OP_DATA_WR) begin
      fresh_q     <= 1'b0;
      cache_ok_q  <= (op_w == OP_READ || op_w == OP_READ_QUICK || op_w == OP_MULTI_READ ||
                      op_w == OP_CACHE_NEXT);
      prog_open_q <= (op_w == OP_PROG_LOAD || op_w == OP_MULTI_SECOND || op_w == OP_COL_CHANGE);
      mopen_q     <= (op_w == OP_MULTI_FIRST);
      msec_q      <= (op_w == OP_MULTI_SECOND) || (msec_q && op_w == OP_COL_CHANGE);
    end
  end

  // Register writes and the refusal flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      col_q     <= 13'h0000;
      row_q     <= 17'h00000;
      row2_q    <= 17'h00000;
      wdata_q   <= 8'h00;
      wp_ctrl_q <= `CTRL_RST_VAL;
      err_q     <= 1'b0;
    end else begin
      if (cmd_wr && !legal) err_q <= 1'b1;
      else if (wb_req && wb_we_i && wb_adr_i == `REG_STAT_OFS && wb_dat_i[`STAT_ERR_BIT]) err_q <= 1'b0;
      if (wb_req && wb_we_i) begin
        case (wb_adr_i)
          `REG_COL_OFS:  col_q  <= wb_dat_i[12:0];
          `REG_ROW_OFS:  row_q  <= wb_dat_i[16:0];
          `REG_ROW2_OFS: row2_q <= wb_dat_i[16:0];
          `REG_DATA_OFS: if (wb_sel_i[0]) wdata_q <= wb_dat_i[7:0];
          `REG_CTRL_OFS: if (wb_sel_i[0]) wp_ctrl_q <= wb_dat_i[`CTRL_WP_N_BIT];
          default:       wdata_q <= wdata_q;
        endcase
      end
    end
  end

  // Captured read data and the pass/fail bit of the last status byte.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q     <= 8'h00;
      fail_q      <= 1'b0;
    end else begin
      if (eng_done && (op_q == OP_DATA_RD || op_q == OP_STATUS) && c_kind == K_DRD) begin
        rdata_q <= eng_rdata;
        if (op_q == OP_STATUS) fail_q <= eng_rdata[0];
      end
    end
  end

  // Pin levels held by this block, and the bus answer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ce_n_o   <= 1'b1;
      wp_n_o   <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ce_n_o   <= (st_q == ST_IDLE) && !cmd_go;
      wp_n_o   <= wp_ctrl_q || (op_q == OP_MULTI_READ && st_q != ST_IDLE) || (cmd_go && op_w == OP_MULTI_READ);
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      case (wb_adr_i)
        `REG_COL_OFS:  wb_dat_o <= {19'h00000, col_q};
        `REG_ROW_OFS:  wb_dat_o <= {15'h0000, row_q};
        `REG_ROW2_OFS: wb_dat_o <= {15'h0000, row2_q};
        `REG_DATA_OFS: wb_dat_o <= {24'h000000, rdata_q};
        `REG_CTRL_OFS: wb_dat_o <= {31'h00000000, wp_ctrl_q};
        `REG_STAT_OFS: wb_dat_o <= {24'h000000, fail_q, msec_q, mopen_q, prog_open_q, cache_ok_q,
                                    err_q, ready_busy_n_i, st_q != ST_IDLE};
        default:       wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  nand_byte_cycle #(
    .LOW_CYC  (`STROBE_LOW_CYC),
    .HIGH_CYC (`STROBE_HIGH_CYC)
  ) u_cycle (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .start_i         (eng_start),
    .kind_i          (c_kind),
    .byte_i          (c_byte),
    .done_o          (eng_done),
    .rdata_o         (eng_rdata),
    .io_i            (io_i),
    .io_o            (io_o),
    .io_oe_o         (io_oe_o),
    .cle_o           (cle_o),
    .ale_o           (ale_o),
    .we_n_o          (we_n_o),
    .read_strobe_n_o (read_strobe_n_o)
  );

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held for more than one cycle");
  a_busy_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_go && !ready_busy_n_i) |-> (op_w == OP_STATUS || op_w == OP_RESET)) else $error("command sent while busy");
  a_mprog_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_go && mopen_q) |-> (op_w inside {OP_STATUS, OP_RESET, OP_MULTI_SECOND})) else $error("illegal op after 11h");
  a_mread_pages: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_go && op_w == OP_MULTI_READ) |-> (row_q[5:0] == row2_q[5:0] && row_q[6] != row2_q[6]))
    else $error("multi read district pages mismatch");
  a_wp_mread: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_q == OP_MULTI_READ && st_q == ST_CYCLE) |-> wp_n_o) else $error("write protect low in multi read");
  a_ready_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == ST_READY && !ready_busy_n_i) |=> st_q == ST_READY) else $error("left busy wait early");
  a_ce_active: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == ST_CYCLE) |-> !ce_n_o) else $error("chip enable high during a pin cycle");
  a_quick_fresh: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_go && op_w == OP_READ_QUICK) |-> fresh_q) else $error("short read after first command");
  a_cache_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_go && op_w inside {OP_CACHE_NEXT, OP_CACHE_LAST}) |-> cache_ok_q) else $error("cache read without start");

  c_read_done: cover property (@(posedge clk_i) op_q == OP_READ && st_q == ST_READY ##1 st_q == ST_IDLE);
  c_mprog_second: cover property (@(posedge clk_i) cmd_go && op_w == OP_MULTI_SECOND);
  c_status_busy: cover property (@(posedge clk_i) cmd_go && op_w == OP_STATUS && !ready_busy_n_i);
endmodule

// >>> tb/nand_flash_model.sv
// Behavioural NAND flash device that answers the sequencer's pin cycles.
`timescale 1ns/100ps
module nand_flash_model #(
  parameter int BUSY_NS = 300
) (
  // Clock used only to time the busy output
  input  wire logic       clk_i,
  // Host pins
  input  wire logic [7:0] io_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       ce_n_i,
  input  wire logic       we_n_i,
  input  wire logic       read_strobe_n_i,
  input  wire logic       wp_n_i,
  // Device outputs
  output logic [7:0]      io_o,
  output logic            ready_busy_n_o
);
  logic [7:0]  cmd_q = 8'h00;
  logic [12:0] col_q = 13'h0000;
  logic [12:0] wcol = 13'h0000;
  logic [16:0] row_q = 17'h00000;
  logic [2:0]  acnt = 3'h0;
  logic        stat_q = 1'b0;
  logic        pend_q = 1'b0;
  logic        fail_q = 1'b0;
  logic [7:0]  dq = 8'h00;
  time         busy_until = 0;
  always @(posedge clk_i) ready_busy_n_o <= ($time >= busy_until);
  // A released bus shows the inverse of the last byte so stale data never matches.
  assign io_o = (!read_strobe_n_i && !ce_n_i) ? dq : ~dq;
  always @(posedge we_n_i) begin
    if (!ce_n_i && cle_i) begin
      cmd_q = io_i;
      stat_q = (io_i == 8'h70);
      acnt = (io_i == 8'h60) ? 3'h2 : 3'h0;
      if (io_i == 8'h31 || io_i == 8'h3f) begin
        row_q = row_q + 17'h00001;
        col_q = 13'h0000;
      end
      if (io_i == 8'h80) pend_q = 1'b0;
      if (io_i == 8'h11) pend_q = (row_q[5:0] == 6'h3f);
      if (io_i == 8'h10) fail_q = pend_q | (row_q[5:0] == 6'h3f);
      if (io_i inside {8'h30, 8'h31, 8'h3f, 8'h10, 8'h11, 8'hff}) busy_until = $time + BUSY_NS;
    end else if (!ce_n_i && ale_i) begin
      case (acnt)
        3'h0: col_q[7:0] = io_i;
        3'h1: col_q[12:8] = io_i[4:0];
        3'h2: row_q[7:0] = io_i;
        3'h3: row_q[15:8] = io_i;
        default: row_q[16] = io_i[0];
      endcase
      acnt = acnt + 3'h1;
    end else if (!ce_n_i) begin
      wcol = col_q;
      col_q = col_q + 13'h0001;
    end
  end
  always @(negedge read_strobe_n_i) begin
    if (!ce_n_i) begin
      dq = stat_q ? {wp_n_i, ready_busy_n_o, ready_busy_n_o, 4'h0, fail_q} : col_q[7:0] + row_q[7:0];
      if (!stat_q) col_q = col_q + 13'h0001;
    end
  end
endmodule

// >>> tb/nand_seq_host_tb.sv
// Self-checking bench for the NAND sequencer against the behavioural flash.
`timescale 1ns/100ps
`include "nand_seq_regs.svh"
module nand_seq_host_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack, oe, cle, ale, ce_n, we_n, re_n, wp_n, rb_n;
  logic [7:0]  h_io, f_io;
  logic [12:0] c;
  logic [16:0] r;
  wire  [7:0]  bus_w = oe ? h_io : f_io;
  int          error_cnt = 0;
  int          total_checks = 0;
  always #5 clk_i = ~clk_i;
  nand_seq_host dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .io_i(bus_w),
    .io_o(h_io), .io_oe_o(oe), .cle_o(cle), .ale_o(ale), .ce_n_o(ce_n), .we_n_o(we_n),
    .read_strobe_n_o(re_n), .wp_n_o(wp_n), .ready_busy_n_i(rb_n));
  nand_flash_model flash (.clk_i(clk_i), .io_i(bus_w), .cle_i(cle), .ale_i(ale), .ce_n_i(ce_n),
    .we_n_i(we_n), .read_strobe_n_i(re_n), .wp_n_i(wp_n), .io_o(f_io), .ready_busy_n_o(rb_n));
  function automatic logic [7:0] f(input logic [12:0] cc, input logic [16:0] rr);
    return cc[7:0] + rr[7:0];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Polls the running flag, bounded so a stuck sequencer cannot hang the bench.
  task automatic op(input logic [3:0] k);
    int n;
    n = 0;
    wb(1'b1, `REG_CMD_OFS, {28'h0, k});
    do begin
      wb(1'b0, `REG_STAT_OFS, 32'h0);
      n++;
    end while (q[0] === 1'b1 && n < 300);
    if (q[0] !== 1'b0) begin
      error_cnt++;
      $display("ERROR %0t: operation did not finish", $time);
    end
  endtask
  task automatic addr(input logic [12:0] cc, input logic [16:0] rr);
    wb(1'b1, `REG_COL_OFS, 32'(cc));
    wb(1'b1, `REG_ROW_OFS, 32'(rr));
  endtask
  task automatic rd();
    op(4'hd);
    wb(1'b0, `REG_DATA_OFS, 32'h0);
  endtask
  task automatic err_clr(input logic e);
    wb(1'b0, `REG_STAT_OFS, 32'h0);
    chk(32'(q[2]), 32'(e));
    wb(1'b1, `REG_STAT_OFS, 32'h4);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    $display("ERROR %0t: timeout", $time);
    complete_run();
  end
  initial begin
    void'($urandom(62));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `REG_CTRL_OFS, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 6'h1c, 32'h0);
    chk(q, 32'h0);
    $display("reset test done");
    c = 13'($urandom);
    r = 17'($urandom);
    addr(c, r);
    op(4'h1);
    rd();
    chk(32'(q[7:0]), 32'(f(c, r)));
    rd();
    chk(32'(q[7:0]), 32'(f(c + 13'h1, r)));
    for (int i = 0; i < 3; i++) begin
      c = 13'($urandom);
      r = 17'($urandom);
      addr(c, r);
      op(4'h0);
      rd();
      chk(32'(q[7:0]), 32'(f(c, r)));
    end
    $display("read test done");
    for (int i = 1; i < 4; i++) begin
      op(i < 3 ? 4'h2 : 4'h3);
      rd();
      chk(32'(q[7:0]), 32'(f(13'h0, r + 17'(i))));
    end
    op(4'h6);
    err_clr(1'b1);
    $display("cache test done");
    r = 17'($urandom);
    wb(1'b1, `REG_ROW_OFS, 32'(r));
    wb(1'b1, `REG_ROW2_OFS, 32'({r[16:7], ~r[6], r[5:0]}));
    op(4'h4);
    err_clr(1'b0);
    wb(1'b1, `REG_ROW2_OFS, 32'({r[16:7], ~r[6], ~r[5:0]}));
    op(4'h4);
    err_clr(1'b1);
    wb(1'b1, `REG_ROW2_OFS, 32'(r));
    op(4'h4);
    err_clr(1'b1);
    $display("multi read test done");
    wb(1'b1, `REG_CTRL_OFS, 32'h1);
    addr(13'($urandom), {11'($urandom), 6'h00});
    op(4'h5);
    for (int i = 0; i < 3; i++) begin
      c = 13'($urandom);
      if (i > 0) wb(1'b1, `REG_COL_OFS, 32'(c));
      if (i > 0) op(4'h6);
      wb(1'b1, `REG_DATA_OFS, 32'($urandom) & 32'hff);
      op(4'hc);
      if (i > 0) chk(32'(flash.wcol), 32'(c));
    end
    op(4'h7);
    op(4'ha);
    wb(1'b0, `REG_DATA_OFS, 32'h0);
    chk(32'(q[7:0]), 32'he0);
    $display("program test done");
    r = {10'($urandom), 1'b0, 6'h3f};
    addr(13'h0000, r);
    op(4'h5);
    op(4'hc);
    op(4'h8);
    op(4'h0);
    err_clr(1'b1);
    addr(13'h0000, {r[16:7], 1'b1, 6'h3f});
    op(4'h9);
    op(4'hc);
    op(4'h7);
    op(4'ha);
    wb(1'b0, `REG_STAT_OFS, 32'h0);
    chk(32'(q[7]), 32'h1);
    op(4'hb);
    err_clr(1'b0);
    $display("multi program test done");
    complete_run();
  end
endmodule
